//--- core/display_host_interface_select.sv
// host bus front end: strap decode, 8080/6800/serial access, rgb pixel capture
`timescale 1ns/100ps
module display_host_interface_select
    import hostif_pkg::*;
#(
    parameter int NUM_RESET_PINS = 8
)(
    // clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      srst_i,
    input  wire logic [NUM_RESET_PINS-1:0] reset_n_i,
    // straps
    input  wire logic                      bus_style_select_i,
    input  wire logic [2:0]                bus_width_select_i,
    input  wire logic                      format_select_i,
    input  wire logic [1:0]                panel_lines_select_i,
    input  wire logic                      extended_command_strap_i,
    input  wire logic                      burn_in_i,
    // host bus pins
    input  wire logic                      chip_select_n_i,
    input  wire logic                      write_strobe_or_direction_i,
    input  wire logic                      read_strobe_or_enable_i,
    input  wire logic                      cmd_param_select_or_serial_clock_i,
    input  wire logic [DATA_W-1:0]         host_data_lines_i,
    output logic      [DATA_W-1:0]         host_data_lines_o,
    output logic                           host_data_lines_oe_o,
    input  wire logic                      serial_in_i,
    output logic                           serial_out_o,
    // rgb port pins
    input  wire logic                      pixel_clock_i,
    input  wire logic                      data_enable_i,
    // core side configuration and status
    input  wire logic                      enable_polarity_i,
    input  wire logic                      discharge_active_i,
    input  wire logic [DATA_W-1:0]         read_data_i,
    output bus_mode_e                      bus_mode_o,
    output bus_width_e                     bus_width_o,
    output logic                           deep_color_o,
    output logic                           format_o,
    output logic                           serial_id_o,
    output logic                           extended_command_o,
    output logic [LINES_W-1:0]             panel_lines_o,
    output logic                           logic_reset_o,
    // core side transfers
    output logic                           host_write_valid_o,
    output logic                           host_write_is_param_o,
    output logic [DATA_W-1:0]              host_write_data_o,
    output logic                           host_read_req_o,
    output logic                           pixel_valid_o,
    output logic [DATA_W-1:0]              pixel_data_o,
    output logic                           burn_in_active_o,
    output logic                           discharge_flag_n_o,
    // sub panel
    input  wire logic                      sub_select_i,
    input  wire logic                      sub_strobe_i,
    input  wire logic                      sub_is_param_i,
    output logic                           sub_write_strobe_n_o,
    output logic                           sub_enable_o,
    output logic                           sub_chip_select_n_o,
    output logic                           sub_index_param_select_o
);

    localparam int SYNC_W = 17 + DATA_W;

    typedef struct packed {
        bus_mode_e          mode;
        bus_width_e         width;
        logic               deep;
        logic               fmt;
        logic               sid;
        logic               ext;
        logic [LINES_W-1:0] lines;
        logic               wr_prev;
        logic               rd_prev;
        logic               scl_prev;
        logic               pclk_prev;
        logic               wr_valid;
        logic               wr_param;
        logic [DATA_W-1:0]  wr_data;
        logic               rd_req;
        logic               drive;
        logic [DATA_W-1:0]  rd_data;
        logic [2:0]         bit_cnt;
        logic [7:0]         rx_shift;
        logic [7:0]         tx_shift;
        logic               first_byte;
        logic               pix_valid;
        logic [DATA_W-1:0]  pix_data;
        logic [11:0]        fr_cnt;
        logic               fr_white;
        logic               burn;
        logic               isd_n;
        logic               sub_cs_n;
        logic               sub_wr_n;
        logic               sub_en;
        logic               sub_rs;
        logic               hold;
    } state_s;

    state_s q;
    state_s d;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] lvl;
    logic              cs_n_s;
    logic              wr_s;
    logic              rd_s;
    logic              dnc_s;
    logic              sdi_s;
    logic              pclk_s;
    logic              de_s;
    logic              rst_pins_s;
    logic              burn_s;
    logic              style_s;
    logic              fmt_s;
    logic              ext_s;
    logic [2:0]        wsel_s;
    logic [1:0]        lsel_s;
    logic [DATA_W-1:0] data_s;
    logic              rst;
    logic              rst_raw;
    logic              cs_act;
    logic [DATA_W-1:0] mask;

    // any one reset pin low pulls the combined level low
    assign pins = {chip_select_n_i, write_strobe_or_direction_i, read_strobe_or_enable_i,
                   cmd_param_select_or_serial_clock_i, serial_in_i, pixel_clock_i, data_enable_i,
                   &reset_n_i, burn_in_i, bus_style_select_i, format_select_i,
                   extended_command_strap_i, bus_width_select_i, panel_lines_select_i,
                   host_data_lines_i};

    pin_sync #(
        .W         (SYNC_W)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .pin_i     (pins),
        .level_o   (lvl)
    );

    assign {cs_n_s, wr_s, rd_s, dnc_s, sdi_s, pclk_s, de_s, rst_pins_s, burn_s, style_s, fmt_s,
            ext_s, wsel_s, lsel_s, data_s} = lvl;

    // sync output starts at zero, so reset holds until the pins have been seen high
    assign rst_raw = srst_i | ~rst_pins_s;
    // straps share the reset pins' synchroniser, so one more cycle lets them settle before capture
    assign rst     = rst_raw | q.hold;

    function automatic bus_mode_e decode_mode(input logic fmt, input logic style, input logic [2:0] ws);
        bus_mode_e m;
        m = MODE_RESERVED;
        if (ws[2:1] == WSEL_SERIAL_HI)
        begin
            m = MODE_SERIAL_RGB;
        end
        else if (fmt == FORMAT_CMD_PARAM)
        begin
            m = MODE_CMD_PARAM;
        end
        else if (ws <= WSEL_8_65K)
        begin
            m = (style == STYLE_6800) ? MODE_M68 : MODE_I80;
        end
        return m;
    endfunction

    function automatic bus_width_e decode_width(input logic fmt, input logic [2:0] ws);
        bus_width_e w;
        w = WIDTH_8;
        if (fmt == FORMAT_REG_CONTENT)
        begin
            case (ws)
                WSEL_16_65K, WSEL_16_262K : w = WIDTH_16;
                WSEL_18_262K              : w = WIDTH_18;
                default                   : w = WIDTH_8;
            endcase
        end
        return w;
    endfunction

    function automatic logic [LINES_W-1:0] decode_lines(input logic [1:0] ls);
        logic [LINES_W-1:0] n;
        case (ls)
            2'h0    : n = LINES_320;
            2'h1    : n = LINES_400;
            2'h2    : n = LINES_432;
            default : n = LINES_480;
        endcase
        return n;
    endfunction

    always_comb
    begin
        d = q;
        case (q.width)
            WIDTH_16 : mask = MASK_16;
            WIDTH_18 : mask = MASK_18;
            default  : mask = MASK_8;
        endcase
        cs_act      = ~cs_n_s && (q.mode != MODE_RESERVED);
        d.wr_prev   = wr_s;
        d.rd_prev   = rd_s;
        d.scl_prev  = dnc_s;
        d.pclk_prev = pclk_s;
        d.wr_valid  = 1'b0;
        d.rd_req    = 1'b0;
        d.drive     = 1'b0;
        d.pix_valid = 1'b0;
        d.rd_data   = read_data_i & mask;
        d.burn      = burn_s;
        d.isd_n     = ~discharge_active_i;
        case (q.mode)
            MODE_I80, MODE_CMD_PARAM :
            begin
                if (cs_act && wr_s && !q.wr_prev)
                begin
                    d.wr_valid = 1'b1;
                    d.wr_param = dnc_s;
                    d.wr_data  = data_s & mask;
                end
                d.drive  = cs_act && !rd_s;
                d.rd_req = cs_act && !rd_s && q.rd_prev;
            end
            MODE_M68 :
            begin
                // write data taken as enable falls, when it is surely settled
                if (cs_act && !rd_s && q.rd_prev && wr_s == DIR_WRITE)
                begin
                    d.wr_valid = 1'b1;
                    d.wr_param = dnc_s;
                    d.wr_data  = data_s & mask;
                end
                d.drive  = cs_act && rd_s && wr_s == DIR_READ;
                d.rd_req = cs_act && rd_s && !q.rd_prev && wr_s == DIR_READ;
            end
            MODE_SERIAL_RGB :
            begin
                if (!cs_act)
                begin
                    d.bit_cnt    = 3'h0;
                    d.first_byte = 1'b1;
                    d.tx_shift   = read_data_i[7:0];
                end
                else if (dnc_s && !q.scl_prev)
                begin
                    d.rx_shift = {q.rx_shift[6:0], sdi_s};
                    d.bit_cnt  = q.bit_cnt + 3'h1;
                    if (q.bit_cnt == 3'(SERIAL_BITS - 1))
                    begin
                        d.wr_valid   = 1'b1;
                        d.wr_param   = ~q.first_byte;
                        d.wr_data    = {10'h000, q.rx_shift[6:0], sdi_s};
                        d.first_byte = 1'b0;
                    end
                end
                else if (!dnc_s && q.scl_prev)
                begin
                    d.tx_shift = {q.tx_shift[6:0], 1'b0};
                end
                if (!burn_s && pclk_s && !q.pclk_prev && (de_s ^ enable_polarity_i))
                begin
                    d.pix_valid = 1'b1;
                    d.pix_data  = data_s;
                end
            end
            default :
            begin
                d.drive = 1'b0;
            end
        endcase
        if (burn_s)
        begin
            // free run overrides any host pixel stream
            d.pix_valid = 1'b1;
            d.pix_data  = q.fr_white ? MASK_18 : '0;
            if (q.fr_cnt == 12'(FREERUN_CYCLES - 1))
            begin
                d.fr_cnt   = 12'h000;
                d.fr_white = ~q.fr_white;
            end
            else
            begin
                d.fr_cnt = q.fr_cnt + 12'h001;
            end
        end
        d.sub_cs_n = ~sub_select_i;
        d.sub_wr_n = ~(sub_strobe_i && q.mode != MODE_M68);
        d.sub_en   = sub_strobe_i && q.mode == MODE_M68;
        d.sub_rs   = sub_is_param_i;
        if (rst)
        begin
            // straps keep being caught until the release, then hold
            d       = '0;
            d.mode  = decode_mode(fmt_s, style_s, wsel_s);
            d.width = decode_width(fmt_s, wsel_s);
            d.deep  = fmt_s && (wsel_s == WSEL_16_262K || wsel_s == WSEL_18_262K || wsel_s == WSEL_8_262K);
            d.fmt   = fmt_s;
            d.sid   = wsel_s[WSEL_ID_POS];
            d.ext   = ext_s;
            d.lines = decode_lines(lsel_s);
            d.first_byte = 1'b1;
            d.isd_n      = DISCHARGE_FLAG_RST;
            d.sub_cs_n   = 1'b1;
            d.sub_wr_n   = 1'b1;
        end
        d.hold = rst_raw;
    end

    always_ff @(posedge clk_sys_i)
    begin
        q <= d;
    end

    assign host_data_lines_o        = q.rd_data;
    assign host_data_lines_oe_o     = q.drive;
    assign serial_out_o             = q.tx_shift[7];
    assign bus_mode_o               = q.mode;
    assign bus_width_o              = q.width;
    assign deep_color_o             = q.deep;
    assign format_o                 = q.fmt;
    assign serial_id_o              = q.sid;
    assign extended_command_o       = q.ext;
    assign panel_lines_o            = q.lines;
    assign logic_reset_o            = rst;
    assign host_write_valid_o       = q.wr_valid;
    assign host_write_is_param_o    = q.wr_param;
    assign host_write_data_o        = q.wr_data;
    assign host_read_req_o          = q.rd_req;
    assign pixel_valid_o            = q.pix_valid;
    assign pixel_data_o             = q.pix_data;
    assign burn_in_active_o         = q.burn;
    assign discharge_flag_n_o       = q.isd_n;
    assign sub_write_strobe_n_o     = q.sub_wr_n;
    assign sub_enable_o             = q.sub_en;
    assign sub_chip_select_n_o      = q.sub_cs_n;
    assign sub_index_param_select_o = q.sub_rs;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst);

    cs_block_a: assert property (cs_n_s |=> !host_write_valid_o && !host_data_lines_oe_o)
        else $error("access accepted with chip select high");
    i80_write_a: assert property ((q.mode == MODE_I80 && cs_act && wr_s && !q.wr_prev)
        |=> host_write_valid_o && host_write_data_o == $past(data_s & mask))
        else $error("8080 write not captured on strobe rise");
    i80_read_a: assert property ((q.mode == MODE_I80 && !cs_n_s && !rd_s) |=> host_data_lines_oe_o)
        else $error("8080 read strobe low without bus drive");
    m68_dir_a: assert property ((q.mode == MODE_M68 && host_data_lines_oe_o) |-> $past(wr_s) == DIR_READ)
        else $error("6800 bus driven while direction says write");
    m68_enable_a: assert property ((q.mode == MODE_M68 && !rd_s && !q.rd_prev)
        |=> !host_write_valid_o && !host_data_lines_oe_o)
        else $error("6800 transfer while enable low");
    width_mask_a: assert property ((host_write_valid_o && q.width == WIDTH_8) |-> host_write_data_o[17:8] == '0)
        else $error("unused upper data lines leaked");
    cmd_param_a: assert property ((host_write_valid_o && q.mode != MODE_SERIAL_RGB)
        |-> host_write_is_param_o == $past(dnc_s))
        else $error("command or parameter select mislatched");
    burn_pixel_a: assert property (burn_s |=> pixel_valid_o && (pixel_data_o == '0 || pixel_data_o == MASK_18))
        else $error("free run pixel not black or white");
    reset_pin_a: assert property (disable iff (srst_i) !rst_pins_s |=> !host_write_valid_o && !host_data_lines_oe_o)
        else $error("logic not held in reset by reset pin");
    discharge_a: assert property (discharge_active_i |=> !discharge_flag_n_o)
        else $error("discharge flag high during discharge");
    lines_hold_a: assert property (!$past(rst) |-> $stable(panel_lines_o) && $stable(bus_mode_o))
        else $error("strap configuration changed outside reset");

    i80_write_c: cover property (q.mode == MODE_I80 && host_write_valid_o);
    m68_read_c: cover property (q.mode == MODE_M68 && host_read_req_o);
    serial_byte_c: cover property (q.mode == MODE_SERIAL_RGB && host_write_valid_o && host_write_is_param_o);
    rgb_pixel_c: cover property (!q.burn && pixel_valid_o);

endmodule // display_host_interface_select

//--- core/hostif_pkg.sv
// constants, field codes and mode types for the display host interface front end
package hostif_pkg;

    localparam int          DATA_W             = 18;
    localparam int          LINES_W            = 10;
    localparam int          SERIAL_BITS        = 8;

    // bus width strap codes
    localparam logic [2:0]  WSEL_16_65K        = 3'h0;
    localparam logic [2:0]  WSEL_16_262K       = 3'h1;
    localparam logic [2:0]  WSEL_18_262K       = 3'h2;
    localparam logic [2:0]  WSEL_8_262K        = 3'h3;
    localparam logic [2:0]  WSEL_8_65K         = 3'h4;
    localparam logic [1:0]  WSEL_SERIAL_HI     = 2'h3;
    localparam int          WSEL_ID_POS        = 0;

    localparam logic        FORMAT_CMD_PARAM   = 1'h0;
    localparam logic        FORMAT_REG_CONTENT = 1'h1;
    localparam logic        STYLE_8080         = 1'h0;
    localparam logic        STYLE_6800         = 1'h1;
    localparam logic        DIR_WRITE          = 1'h0;
    localparam logic        DIR_READ           = 1'h1;

    localparam logic [17:0] MASK_8             = 18'h000ff;
    localparam logic [17:0] MASK_16            = 18'h0ffff;
    localparam logic [17:0] MASK_18            = 18'h3ffff;

    // panel line counts per resolution strap code 0..3
    localparam logic [9:0]  LINES_320          = 10'h140;
    localparam logic [9:0]  LINES_400          = 10'h190;
    localparam logic [9:0]  LINES_432          = 10'h1b0;
    localparam logic [9:0]  LINES_480          = 10'h1e0;

    // free-run frame period
    localparam int          CLK_MHZ            = 250;
    localparam int          FREERUN_FRAME_US   = 16;
    localparam int          FREERUN_CYCLES     = FREERUN_FRAME_US * CLK_MHZ;

    localparam logic        DISCHARGE_FLAG_RST = 1'h1;

    typedef enum logic [2:0] {
        MODE_RESERVED   = 3'h0,
        MODE_I80        = 3'h1,
        MODE_M68        = 3'h3,
        MODE_SERIAL_RGB = 3'h2,
        MODE_CMD_PARAM  = 3'h6
    } bus_mode_e;

    typedef enum logic [1:0] {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_18 = 2'h3
    } bus_width_e;

endpackage

//--- core/pin_sync.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
module pin_sync
    import hostif_pkg::*;
#(
    parameter int W = 1
)(
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    // pins in, filtered levels out
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s q;
    sync_s d;
    logic [W-1:0] agree;

    // s1 is read only by s2, so no logic looks at a metastable stage
    always_comb
    begin
        d     = q;
        d.s1  = pin_i;
        d.s2  = q.s1;
        d.s3  = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.lvl = (agree & q.s3) | (~agree & q.lvl);
        if (srst_i)
        begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        q <= d;
    end

    assign level_o = q.lvl;

endmodule // pin_sync

//--- tb/host_model.sv
// host processor model driving the parallel bus pins
`timescale 1ns/100ps
module host_model
    import hostif_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         m68_i,
    output logic              cs_n_o,
    output logic              wr_o,
    output logic              rd_o,
    output logic              dnc_o,
    output logic [DATA_W-1:0] d_o
);
    // six cycles per phase clears the three-flop pin sync
    task automatic step();
        repeat (6) @(posedge clk_sys_i);
    endtask
    // released bus shows the inverse, never the last value
    task automatic idle(input logic [DATA_W-1:0] d);
        cs_n_o <= 1'b1;
        wr_o   <= 1'b1;
        rd_o   <= !m68_i;
        dnc_o  <= 1'b0;
        d_o    <= ~d;
    endtask
    task automatic put_word(input logic cs_n, input logic dnc, input logic [DATA_W-1:0] d);
        cs_n_o <= cs_n;
        dnc_o  <= dnc;
        d_o    <= d;
        wr_o   <= m68_i ? DIR_WRITE : 1'b0;
        rd_o   <= !m68_i;
        step();
        rd_o   <= 1'b1;
        wr_o   <= !m68_i ? 1'b1 : DIR_WRITE;
        step();
        rd_o   <= !m68_i;
        step();
        idle(d);
        step();
    endtask
    task automatic get_word();
        cs_n_o <= 1'b0;
        wr_o   <= m68_i ? DIR_READ : 1'b1;
        rd_o   <= m68_i;
        step();
        step();
        idle(d_o);
        step();
    endtask
    initial idle('0);
endmodule // host_model

//--- tb/display_host_interface_select_test.sv
// self-checking bench for the host interface front end
`timescale 1ns/100ps
module display_host_interface_select_test
    import hostif_pkg::*;
();
    logic clk_sys_i = 1'b0, srst_i = 1'b1, m68 = 1'b0, fmt = 1'b1, burn = 1'b0, dis = 1'b0, ext = 1'b0, xo;
    logic [7:0] rst_n = 8'hff;
    logic [2:0] wsel = 3'h0, sub = 3'h0;
    logic [1:0] res = 2'h0;
    logic [DATA_W-1:0] rdat = '0, dout, bus, hd, wd, pd, d;
    logic cs_n, wr, rd, dnc, oe, deep, lrst, wv, wp, rq, pv, bact, dfl, sid, s_wr, s_en, s_cs, s_rs;
    logic [LINES_W-1:0] lines;
    bus_mode_e mode;
    bus_width_e wid;
    int errors = 0, n_tests = 0, cyc = 0;
    logic [18:0] wq[$], rq_q[$];
    logic [9:0] nl[4] = '{10'h140, 10'h190, 10'h1b0, 10'h1e0};
    logic [2:0] wc[3] = '{3'h0, 3'h2, 3'h4};
    logic [17:0] mk[3] = '{18'h0ffff, 18'h3ffff, 18'h000ff};
    assign bus = oe ? dout : hd;
    always #2 clk_sys_i = ~clk_sys_i;
    host_model hm (.clk_sys_i, .m68_i(m68), .cs_n_o(cs_n), .wr_o(wr), .rd_o(rd), .dnc_o(dnc), .d_o(hd));
    display_host_interface_select dut (.clk_sys_i, .srst_i, .reset_n_i(rst_n), .bus_style_select_i(m68),
        .bus_width_select_i(wsel), .format_select_i(fmt), .panel_lines_select_i(res),
        .extended_command_strap_i(ext), .burn_in_i(burn), .chip_select_n_i(cs_n),
        .write_strobe_or_direction_i(wr), .read_strobe_or_enable_i(rd), .cmd_param_select_or_serial_clock_i(dnc),
        .host_data_lines_i(bus), .host_data_lines_o(dout), .host_data_lines_oe_o(oe), .serial_in_i(1'b1),
        .serial_out_o(), .pixel_clock_i(1'b0), .data_enable_i(1'b0), .enable_polarity_i(1'b0),
        .discharge_active_i(dis), .read_data_i(rdat), .bus_mode_o(mode), .bus_width_o(wid), .deep_color_o(deep),
        .format_o(), .serial_id_o(sid), .extended_command_o(xo), .panel_lines_o(lines), .logic_reset_o(lrst),
        .host_write_valid_o(wv), .host_write_is_param_o(wp), .host_write_data_o(wd), .host_read_req_o(rq),
        .pixel_valid_o(pv), .pixel_data_o(pd), .burn_in_active_o(bact), .discharge_flag_n_o(dfl),
        .sub_select_i(sub[2]), .sub_strobe_i(sub[1]), .sub_is_param_i(sub[0]), .sub_write_strobe_n_o(s_wr),
        .sub_enable_o(s_en), .sub_chip_select_n_o(s_cs), .sub_index_param_select_o(s_rs));
    task automatic cmp(input logic [18:0] got, input logic [18:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic bus_mode_e exp_mode(input logic [4:0] c);
        if (c[2:1] == 2'h3)
            return MODE_SERIAL_RGB;
        if (!c[4])
            return MODE_CMD_PARAM;
        if (c[2:0] > 3'h4)
            return MODE_RESERVED;
        return c[3] ? MODE_M68 : MODE_I80;
    endfunction
    task automatic settle();
        for (int i = 0; i < 20 && lrst !== 1'b0; i++)
            @(posedge clk_sys_i);
        cmp(19'(lrst), 19'h0, "reset release");
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic boot(input logic s, input logic [2:0] w, input logic f, input logic [1:0] r);
        m68    <= s;
        wsel   <= w;
        fmt    <= f;
        res    <= r;
        srst_i <= 1'b1;
        @(posedge clk_sys_i);
        hm.idle('0);
        @(posedge clk_sys_i);
        srst_i <= 1'b0;
        settle();
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (wv === 1'b1)
            cmp({wp, wd}, wq.size() ? wq.pop_front() : 19'h7ffff, "write");
        if (rq === 1'b1)
            cmp({oe, dout}, rq_q.size() ? rq_q.pop_front() : 19'h0, "read");
        if (cyc == 10000)
        begin
            errors++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'h6b00));
        for (int i = 0; i < 32; i++)
        begin
            ext <= i[0];
            boot(i[3], i[2:0], i[4], i[1:0]);
            cmp(19'(xo), 19'(i[0]), "extended strap");
            cmp(19'(mode), 19'(exp_mode(i[4:0])), "mode");
            cmp(19'(lines), 19'(nl[i[1:0]]), "lines");
            if (exp_mode(i[4:0]) inside {MODE_I80, MODE_M68})
                cmp(19'({wid, deep}), 19'({i[2:0] == 3'h2 ? WIDTH_18 : (i[2:0] < 3'h2 ? WIDTH_16 : WIDTH_8),
                    i[2:0] inside {3'h1, 3'h2, 3'h3}}), "width");
            if (i[2:1] == 2'h3)
                cmp(19'(sid), 19'(i[0]), "serial id");
        end
        $display("test strap modes done");
        for (int i = 0; i < 6; i++)
        begin
            boot(i[0], wc[i/2], 1'b1, 2'h3);
            for (int k = 0; k < 3; k++)
            begin
                d = DATA_W'($urandom);
                wq.push_back({k[0], d & mk[i/2]});
                hm.put_word(1'b0, k[0], d);
            end
            hm.put_word(1'b1, 1'b1, d);
            rdat <= DATA_W'($urandom);
            @(posedge clk_sys_i);
            rq_q.push_back({1'b1, rdat & mk[i/2]});
            hm.get_word();
        end
        cmp(19'(wq.size() + rq_q.size()), 19'h0, "transfers left");
        $display("test bus transfers done");
        sub <= 3'h7;
        dis <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        cmp(19'({s_cs, s_wr, s_en, s_rs, dfl}), 19'h0e, "sub panel");
        dis <= 1'b0;
        rst_n <= 8'hef;
        repeat (8) @(posedge clk_sys_i);
        cmp(19'({lrst, dfl}), 19'h3, "reset pin");
        rst_n <= 8'hff;
        settle();
        $display("test side outputs done");
        boot(1'b0, 3'h6, 1'b1, 2'h0);
        burn <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        cmp({pv, bact, pd[16:0]}, 19'h60000, "black frame");
        repeat (4000) @(posedge clk_sys_i);
        cmp({pv, bact, pd[16:0]}, 19'h7ffff, "white frame");
        $display("test free run done");
        report_and_stop();
    end
endmodule // display_host_interface_select_test
